/* File: drive_mode_stop_selector.sv */
// Operation mode selection and quick-stop / halt action decoding.
//
// Contract
// - Velocity/homing quick stop 0 coasts, de-energized; code 4 unusable.
// - Velocity/homing codes 1,5 ramp profile decel (homing accel); 5 locks.
// - Velocity/homing codes 2,6 ramp quick stop decel; 6 locks position.
// - Velocity/homing codes 3,7 brake emergency torque; 7 locks position.
// - Torque modes: quick stop 7 and halt 3 coast, position locked.
// - Torque modes: halt 2 ramps by torque slope, then position locked.
// - Halt option accepts 1 to 3, defaults 1, not process mapped.
// - Profile position halt 1 profile decel, 2 quick stop decel; lock.
// - Profile position halt 3 brakes emergency torque, de-energized.
// - Velocity/homing halt 3 emergency torque locked; 1,2 like quick stop.
// - Mode request is signed 8-bit, range 0 to 10, process mappable.
// - Modes 8, 9, 10 select cyclic position, velocity, torque.
// - Mode 7, interpolated position, is unsupported.
// - Unsupported mode by service write is rejected with an abort.
// - Unsupported mode by process data is ignored; mode is kept.
// - Read-only mode display reports active mode, default 0.
// - Quick stop option is signed 16-bit, range 0 to 7, default 2.
`timescale 1ns/1ps

module drive_mode_stop_selector
	import drive_mode_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         sdo_valid,
	input  wire logic         sdo_write,
	input  wire logic [15:0]  sdo_index,
	input  wire logic [15:0]  sdo_wdata,
	input  wire logic         pdo_mode_valid,
	input  wire logic [7:0]   pdo_mode,
	input  wire logic [15:0]  control_word,
	input  wire logic         quick_stop_req,
	output logic              sdo_done,
	output sdo_ack_t          sdo_ack,
	output logic [15:0]       sdo_rdata,
	output logic [7:0]        mode_display,
	output logic              stop_active,
	output stop_source_t      stop_source,
	output logic              stop_lock_position
);

	logic [15:0] quick_stop_option;
	logic [15:0] halt_stop_option;
	logic [7:0]  operation_mode_request;
	logic [7:0]  operation_mode_display;

	// Modes the drive can run; reserved values and interpolated are out.
	function automatic logic mode_supported(input logic [7:0] m);
		mode_supported = (m == MODE_PROFILE_POSITION) ||
			(m == MODE_PROFILE_VELOCITY) || (m == MODE_PROFILE_TORQUE) ||
			(m == MODE_HOMING) || (m == MODE_CYCLIC_SYNC_POSITION) ||
			(m == MODE_CYCLIC_SYNC_VELOCITY) ||
			(m == MODE_CYCLIC_SYNC_TORQUE);
	endfunction : mode_supported

	function automatic logic is_vel_homing(input logic [7:0] m);
		is_vel_homing = (m == MODE_PROFILE_VELOCITY) ||
			(m == MODE_CYCLIC_SYNC_VELOCITY) || (m == MODE_HOMING);
	endfunction : is_vel_homing

	function automatic logic is_torque(input logic [7:0] m);
		is_torque = (m == MODE_PROFILE_TORQUE) ||
			(m == MODE_CYCLIC_SYNC_TORQUE);
	endfunction : is_torque

	function automatic stop_source_t ramp_decel(input logic [7:0] m);
		ramp_decel = (m == MODE_HOMING) ? SRC_HOMING_ACCEL
			: SRC_PROFILE_DECEL;
	endfunction : ramp_decel

	logic sdo_wr;
	logic sdo_mode_bad;
	logic qs_bad;
	logic halt_bad;
	assign sdo_wr       = sdo_valid && sdo_write;
	assign sdo_mode_bad = !mode_supported(sdo_wdata[7:0]) ||
		(sdo_wdata[15:8] != {8{sdo_wdata[7]}});
	assign qs_bad   = sdo_wdata > QUICK_STOP_MAX;
	assign halt_bad = (sdo_wdata < HALT_MIN) || (sdo_wdata > HALT_MAX);

	// Service writes of option codes; out-of-range values abort.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			quick_stop_option <= QUICK_STOP_RESET;
			halt_stop_option  <= HALT_RESET;
		end else if (sdo_wr) begin
			if (sdo_index == IDX_QUICK_STOP_OPTION && !qs_bad) begin
				quick_stop_option <= sdo_wdata;
			end else if (sdo_index == IDX_HALT_STOP_OPTION && !halt_bad) begin
				halt_stop_option <= sdo_wdata;
			end
		end
	end

	// Mode request: service write wins over process data in the same cycle.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			operation_mode_request <= MODE_RESET;
		end else if (sdo_wr && sdo_index == IDX_MODE_REQUEST) begin
			if (!sdo_mode_bad) begin
				operation_mode_request <= sdo_wdata[7:0];
			end
		end else if (pdo_mode_valid && mode_supported(pdo_mode)) begin
			operation_mode_request <= pdo_mode;
		end
	end

	// The active mode follows a supported request one cycle later.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			operation_mode_display <= MODE_RESET;
		end else if (mode_supported(operation_mode_request)) begin
			operation_mode_display <= operation_mode_request;
		end
	end

	// Service answers, one cycle after the request.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sdo_done  <= 1'b0;
			sdo_ack   <= ACK_OK;
			sdo_rdata <= 16'h0000;
		end else begin
			sdo_done <= sdo_valid;
			if (sdo_valid) begin
				sdo_ack   <= ACK_OK;
				sdo_rdata <= 16'h0000;
				if (sdo_index == IDX_QUICK_STOP_OPTION) begin
					sdo_rdata <= quick_stop_option;
					if (sdo_write && qs_bad) begin
						sdo_ack <= ACK_ABORT_RANGE;
					end
				end else if (sdo_index == IDX_HALT_STOP_OPTION) begin
					sdo_rdata <= halt_stop_option;
					if (sdo_write && halt_bad) begin
						sdo_ack <= ACK_ABORT_RANGE;
					end
				end else if (sdo_index == IDX_MODE_REQUEST) begin
					sdo_rdata <= {{8{operation_mode_request[7]}},
						operation_mode_request};
					if (sdo_write && sdo_mode_bad) begin
						sdo_ack <= ACK_ABORT_RANGE;
					end
				end else if (sdo_index == IDX_MODE_DISPLAY) begin
					sdo_rdata <= {{8{operation_mode_display[7]}},
						operation_mode_display};
					if (sdo_write) begin
						sdo_ack <= ACK_ABORT_READ_ONLY;
					end
				end else begin
					sdo_ack <= ACK_ABORT_NO_OBJECT;
				end
			end
		end
	end

	// Stop action decode from the active mode and the option codes.
	logic         halt_req;
	logic         next_active;
	stop_source_t next_source;
	logic         next_lock;
	logic [7:0]   m;
	assign halt_req = control_word[HALT_BIT_POS[3:0]];
	assign m        = operation_mode_display;

	always_comb begin
		next_active = 1'b0;
		next_source = SRC_NONE;
		next_lock   = 1'b0;
		if (quick_stop_req) begin
			next_active = 1'b1;
			next_lock   = quick_stop_option[2];
			if (quick_stop_option[1:0] == 2'd0) begin
				next_source = SRC_COAST;
			end else if (is_torque(m)) begin
				next_source = (quick_stop_option[1:0] == 2'd3) ? SRC_COAST
					: SRC_TORQUE_SLOPE;
			end else if (m == MODE_CYCLIC_SYNC_POSITION) begin
				next_source = SRC_EMERGENCY_TORQUE;
			end else if (quick_stop_option[1:0] == 2'd1) begin
				next_source = ramp_decel(m);
			end else if (quick_stop_option[1:0] == 2'd2) begin
				next_source = SRC_QUICK_STOP_DECEL;
			end else begin
				next_source = SRC_EMERGENCY_TORQUE;
			end
			// Code 4 is not usable: it coasts and de-energizes.
			if (quick_stop_option[2:0] == 3'd4) begin
				next_source = SRC_COAST;
				next_lock   = 1'b0;
			end
		end else if (halt_req) begin
			next_active = 1'b1;
			next_lock   = 1'b1;
			if (is_torque(m)) begin
				next_source = (halt_stop_option[1:0] == 2'd3) ? SRC_COAST
					: SRC_TORQUE_SLOPE;
			end else if (m == MODE_CYCLIC_SYNC_POSITION) begin
				next_source = SRC_EMERGENCY_TORQUE;
			end else if (halt_stop_option[1:0] == 2'd1) begin
				next_source = ramp_decel(m);
			end else if (halt_stop_option[1:0] == 2'd2) begin
				next_source = SRC_QUICK_STOP_DECEL;
			end else begin
				next_source = SRC_EMERGENCY_TORQUE;
				next_lock   = (m != MODE_PROFILE_POSITION);
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stop_active        <= 1'b0;
			stop_source        <= SRC_NONE;
			stop_lock_position <= 1'b0;
			mode_display       <= MODE_RESET;
		end else begin
			stop_active        <= next_active;
			stop_source        <= next_source;
			stop_lock_position <= next_lock;
			mode_display       <= operation_mode_display;
		end
	end

	AST_QS_CODE0_COAST: assert property (
		@(posedge core_clk) disable iff (reset)
		quick_stop_req && quick_stop_option == 16'h0000 |=>
		stop_source == SRC_COAST && !stop_lock_position)
		else $error("quick stop code 0 did not coast");
	AST_QS_RAMP: assert property (
		@(posedge core_clk) disable iff (reset)
		quick_stop_req && is_vel_homing(m) && quick_stop_option[1:0] == 2'd1
		|=> stop_lock_position == $past(quick_stop_option[2]) &&
		stop_source == (($past(m) == MODE_HOMING) ? SRC_HOMING_ACCEL
		: SRC_PROFILE_DECEL))
		else $error("quick stop profile ramp source wrong");
	AST_QS_QSDECEL: assert property (
		@(posedge core_clk) disable iff (reset)
		quick_stop_req && is_vel_homing(m) && quick_stop_option == 16'h0006
		|=> stop_source == SRC_QUICK_STOP_DECEL && stop_lock_position)
		else $error("quick stop code 6 wrong");
	AST_QS_EMERG: assert property (
		@(posedge core_clk) disable iff (reset)
		quick_stop_req && is_vel_homing(m) && quick_stop_option == 16'h0003
		|=> stop_source == SRC_EMERGENCY_TORQUE && !stop_lock_position)
		else $error("quick stop code 3 wrong");
	AST_TORQUE_HALT3: assert property (
		@(posedge core_clk) disable iff (reset)
		!quick_stop_req && halt_req && is_torque(m) && halt_stop_option == 16'h3
		|=> stop_source == SRC_COAST && stop_lock_position)
		else $error("torque halt 3 did not coast locked");
	AST_TORQUE_HALT2: assert property (
		@(posedge core_clk) disable iff (reset)
		!quick_stop_req && halt_req && is_torque(m) && halt_stop_option == 16'h2
		|=> stop_source == SRC_TORQUE_SLOPE)
		else $error("torque halt 2 not torque slope");
	AST_HALT_RANGE: assert property (
		@(posedge core_clk) disable iff (reset)
		halt_stop_option >= HALT_MIN && halt_stop_option <= HALT_MAX)
		else $error("halt option out of range");
	AST_PP_HALT2: assert property (
		@(posedge core_clk) disable iff (reset)
		!quick_stop_req && halt_req && m == MODE_PROFILE_POSITION &&
		halt_stop_option == 16'h2
		|=> stop_source == SRC_QUICK_STOP_DECEL && stop_lock_position)
		else $error("profile position halt 2 wrong");
	AST_PP_HALT3: assert property (
		@(posedge core_clk) disable iff (reset)
		!quick_stop_req && halt_req && m == MODE_PROFILE_POSITION &&
		halt_stop_option == 16'h3 |=> !stop_lock_position)
		else $error("profile position halt 3 locked");
	AST_VEL_HALT3: assert property (
		@(posedge core_clk) disable iff (reset)
		!quick_stop_req && halt_req && is_vel_homing(m) &&
		halt_stop_option == 16'h3
		|=> stop_source == SRC_EMERGENCY_TORQUE && stop_lock_position)
		else $error("velocity halt 3 not emergency locked");
	AST_SDO_ABORT: assert property (
		@(posedge core_clk) disable iff (reset)
		sdo_wr && sdo_index == IDX_MODE_REQUEST && sdo_mode_bad
		|=> sdo_done && sdo_ack == ACK_ABORT_RANGE &&
		$stable(operation_mode_request))
		else $error("bad mode write not aborted");
	AST_PDO_IGNORE: assert property (
		@(posedge core_clk) disable iff (reset)
		!sdo_wr && pdo_mode_valid && !mode_supported(pdo_mode)
		|=> $stable(operation_mode_request))
		else $error("bad process data mode accepted");
	// Looks at the active mode two edges on, so back-to-back writes are legal.
	AST_DISPLAY: assert property (
		@(posedge core_clk) disable iff (reset)
		sdo_wr && sdo_index == IDX_MODE_REQUEST && !sdo_mode_bad
		|=> ##1 operation_mode_display == $past(sdo_wdata[7:0], 2))
		else $error("display did not follow request");

	COV_QS_LOCK: cover property (@(posedge core_clk) disable iff (reset)
		stop_active && stop_lock_position && stop_source == SRC_QUICK_STOP_DECEL);
	COV_HALT_TORQUE: cover property (@(posedge core_clk) disable iff (reset)
		stop_active && stop_source == SRC_TORQUE_SLOPE);
	COV_MODE_CSV: cover property (@(posedge core_clk) disable iff (reset)
		mode_display == MODE_CYCLIC_SYNC_VELOCITY);
	COV_ABORT: cover property (@(posedge core_clk) disable iff (reset)
		sdo_done && sdo_ack == ACK_ABORT_RANGE);

endmodule : drive_mode_stop_selector

/* File: drive_mode_pkg.sv */
// Object indices, codes and reset values for the mode and stop selector.
package drive_mode_pkg;

	localparam logic [15:0] IDX_QUICK_STOP_OPTION = 16'h605a;
	localparam logic [15:0] IDX_HALT_STOP_OPTION  = 16'h605d;
	localparam logic [15:0] IDX_MODE_REQUEST      = 16'h6060;
	localparam logic [15:0] IDX_MODE_DISPLAY      = 16'h6061;

	localparam logic [15:0] QUICK_STOP_RESET = 16'h0002;
	localparam logic [15:0] QUICK_STOP_MAX   = 16'h0007;
	localparam logic [15:0] HALT_RESET       = 16'h0001;
	localparam logic [15:0] HALT_MIN         = 16'h0001;
	localparam logic [15:0] HALT_MAX         = 16'h0003;
	localparam logic [7:0]  MODE_RESET       = 8'h00;
	localparam logic [7:0]  MODE_MAX         = 8'h0a;

	localparam logic [7:0] MODE_PROFILE_POSITION      = 8'h01;
	localparam logic [7:0] MODE_PROFILE_VELOCITY      = 8'h03;
	localparam logic [7:0] MODE_PROFILE_TORQUE        = 8'h04;
	localparam logic [7:0] MODE_HOMING                = 8'h06;
	localparam logic [7:0] MODE_INTERPOLATED_POSITION = 8'h07;
	localparam logic [7:0] MODE_CYCLIC_SYNC_POSITION  = 8'h08;
	localparam logic [7:0] MODE_CYCLIC_SYNC_VELOCITY  = 8'h09;
	localparam logic [7:0] MODE_CYCLIC_SYNC_TORQUE    = 8'h0a;

	localparam logic [15:0] HALT_BIT_POS = 16'h0008;

	// Where the ramp rate comes from while the motor is brought to rest.
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_COAST,
		SRC_PROFILE_DECEL,
		SRC_HOMING_ACCEL,
		SRC_QUICK_STOP_DECEL,
		SRC_TORQUE_SLOPE,
		SRC_EMERGENCY_TORQUE
	} stop_source_t;

	typedef enum logic [1:0] {
		ACK_OK,
		ACK_ABORT_RANGE,
		ACK_ABORT_READ_ONLY,
		ACK_ABORT_NO_OBJECT
	} sdo_ack_t;

endpackage : drive_mode_pkg

/* File: fieldbus_master.sv */
// Fieldbus master model that issues service and process data requests.
`timescale 1ns/1ps

module fieldbus_master (
	input  wire logic   core_clk,
	output logic        sdo_valid,
	output logic        sdo_write,
	output logic [15:0] sdo_index,
	output logic [15:0] sdo_wdata,
	output logic        pdo_mode_valid,
	output logic [7:0]  pdo_mode,
	output logic [15:0] control_word,
	output logic        quick_stop_req
);
	initial begin
		sdo_valid = 1'b0;
		sdo_write = 1'b0;
		sdo_index = 16'h0000;
		sdo_wdata = 16'h0000;
		pdo_mode_valid = 1'b0;
		pdo_mode = 8'h00;
		control_word = 16'h0000;
		quick_stop_req = 1'b0;
	end

	// Released qualifiers show the inverse so stale values never match.
	task sdo_req(input logic w, input logic [15:0] idx, input logic [15:0] d);
		@(posedge core_clk);
		#10;
		sdo_valid = 1'b1;
		sdo_write = w;
		sdo_index = idx;
		sdo_wdata = d;
		@(posedge core_clk);
		#10;
		sdo_valid = 1'b0;
		sdo_write = ~w;
		sdo_index = ~idx;
		sdo_wdata = ~d;
	endtask : sdo_req

	task pdo_req(input logic [7:0] d);
		@(posedge core_clk);
		#10;
		pdo_mode_valid = 1'b1;
		pdo_mode = d;
		@(posedge core_clk);
		#10;
		pdo_mode_valid = 1'b0;
		pdo_mode = ~d;
	endtask : pdo_req

	// Halt is requested only through bit 8 of the control word.
	task set_stop(input logic qs, input logic [15:0] cw);
		@(posedge core_clk);
		#10;
		quick_stop_req = qs;
		control_word = cw;
	endtask : set_stop
endmodule : fieldbus_master

/* File: tb_top.sv */
// Self-checking bench for the mode and stop selector.
`timescale 1ns/1ps
`define chk(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
fail_count++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module tb_top
	import drive_mode_pkg::*;
;
	typedef struct packed {
		sdo_ack_t    ack;
		logic [15:0] rd;
		logic        rc;
	} exp_t;

	logic core_clk, reset, sdo_valid, sdo_write, pdo_mode_valid;
	logic quick_stop_req, sdo_done, stop_active, stop_lock_position, ok;
	logic [15:0] sdo_index, sdo_wdata, control_word, sdo_rdata;
	logic [7:0] pdo_mode, mode_display, cur, v;
	sdo_ack_t sdo_ack;
	stop_source_t stop_source;
	exp_t exp_q[$];
	exp_t e;
	int fail_count, cmp_count, i, c, j;
	logic [7:0] modes [7] = '{8'h03, 8'h06, 8'h04, 8'h01, 8'h0a, 8'h09,
		8'h08};

	fieldbus_master u_fieldbus_master (.core_clk(core_clk),
		.sdo_valid(sdo_valid), .sdo_write(sdo_write), .sdo_index(sdo_index),
		.sdo_wdata(sdo_wdata), .pdo_mode_valid(pdo_mode_valid),
		.pdo_mode(pdo_mode), .control_word(control_word),
		.quick_stop_req(quick_stop_req));

	drive_mode_stop_selector u_drive_mode_stop_selector (.core_clk(core_clk),
		.reset(reset), .sdo_valid(sdo_valid), .sdo_write(sdo_write),
		.sdo_index(sdo_index), .sdo_wdata(sdo_wdata),
		.pdo_mode_valid(pdo_mode_valid), .pdo_mode(pdo_mode),
		.control_word(control_word), .quick_stop_req(quick_stop_req),
		.sdo_done(sdo_done), .sdo_ack(sdo_ack), .sdo_rdata(sdo_rdata),
		.mode_display(mode_display), .stop_active(stop_active),
		.stop_source(stop_source), .stop_lock_position(stop_lock_position));

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	task final_report;
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	always @(negedge core_clk) begin
		if (sdo_done === 1'b1) begin
			e = exp_q.pop_front();
			`chk("sdo_ack", e.ack, sdo_ack)
			if (e.rc)
				`chk("sdo_rdata", e.rd, sdo_rdata)
		end
	end

	task sdo(input logic w, input logic [15:0] idx, input logic [15:0] d,
		input sdo_ack_t a, input logic [15:0] rd, input logic rc);
		exp_q.push_back('{a, rd, rc});
		u_fieldbus_master.sdo_req(w, idx, d);
		repeat (2) @(posedge core_clk);
	endtask : sdo

	// Returns the ending lock flag above the expected ramp source.
	function automatic logic [3:0] stop_exp(input logic [7:0] m,
		input logic qs, input logic [2:0] k);
		logic tq;
		logic cp;
		stop_source_t r;
		tq = (m == MODE_PROFILE_TORQUE) || (m == MODE_CYCLIC_SYNC_TORQUE);
		cp = (m == MODE_CYCLIC_SYNC_POSITION);
		r = (m == MODE_HOMING) ? SRC_HOMING_ACCEL : SRC_PROFILE_DECEL;
		if (qs && tq)
			return {k[2] && k[1:0] != 2'd0,
				(k[1:0] == 2'd1 || k[1:0] == 2'd2) ?
				SRC_TORQUE_SLOPE : SRC_COAST};
		// Cyclic position brakes at emergency torque for every non-coast code.
		if (qs && cp && k[1:0] != 2'd0)
			return {k[2], SRC_EMERGENCY_TORQUE};
		if (qs) case (k[1:0])
			2'd1: return {k[2], r};
			2'd2: return {k[2], SRC_QUICK_STOP_DECEL};
			2'd3: return {k[2], SRC_EMERGENCY_TORQUE};
			default: return {1'b0, SRC_COAST};
		endcase
		if (cp)
			return {1'b1, SRC_EMERGENCY_TORQUE};
		if (tq)
			return {1'b1, (k == 3'd3) ? SRC_COAST : SRC_TORQUE_SLOPE};
		if (k == 3'd1)
			return {1'b1, r};
		if (k == 3'd2)
			return {1'b1, SRC_QUICK_STOP_DECEL};
		return {m != MODE_PROFILE_POSITION, SRC_EMERGENCY_TORQUE};
	endfunction : stop_exp

	task check_stop(input logic [7:0] m, input logic qs, input logic [2:0] k);
		logic [3:0] x;
		x = stop_exp(m, qs, k);
		repeat (2) @(posedge core_clk);
		`chk("stop_active", 1'b1, stop_active)
		`chk("stop_source", x[2:0], stop_source)
		`chk("stop_lock", x[3], stop_lock_position)
	endtask : check_stop

	initial begin
		#2000000;
		fail_count++;
		final_report;
	end

	initial begin
		void'($urandom(44));
		reset = 1'b1;
		repeat (4) @(posedge core_clk);
		#10 reset = 1'b0;
		sdo(0, IDX_HALT_STOP_OPTION, 0, ACK_OK, HALT_RESET, 1);
		sdo(0, IDX_QUICK_STOP_OPTION, 0, ACK_OK, QUICK_STOP_RESET, 1);
		sdo(0, IDX_MODE_DISPLAY, 0, ACK_OK, 16'h0000, 1);
		sdo(1, IDX_MODE_DISPLAY, 3, ACK_ABORT_READ_ONLY, 0, 0);
		sdo(1, 16'h6062, 0, ACK_ABORT_NO_OBJECT, 0, 0);
		sdo(1, IDX_HALT_STOP_OPTION, 0, ACK_ABORT_RANGE, 0, 0);
		sdo(1, IDX_HALT_STOP_OPTION, 16'h4 + 16'($urandom % 500),
			ACK_ABORT_RANGE, 0, 0);
		sdo(0, IDX_HALT_STOP_OPTION, 0, ACK_OK, HALT_RESET, 1);
		sdo(1, IDX_QUICK_STOP_OPTION, 16'h8 + 16'($urandom % 500),
			ACK_ABORT_RANGE, 0, 0);
		sdo(1, IDX_QUICK_STOP_OPTION, 16'hffff, ACK_ABORT_RANGE, 0, 0);
		cur = MODE_RESET;
		for (i = 0; i <= 12; i++) begin
			ok = i inside {1, 3, 4, 6, 8, 9, 10};
			sdo(1, IDX_MODE_REQUEST, 16'(i), ok ? ACK_OK : ACK_ABORT_RANGE,
				0, 0);
			cur = ok ? 8'(i) : cur;
			repeat (2) @(posedge core_clk);
			`chk("mode_display", cur, mode_display)
		end
		sdo(1, IDX_MODE_REQUEST, 16'hfffc, ACK_ABORT_RANGE, 0, 0);
		sdo(1, IDX_MODE_REQUEST, 16'h0103, ACK_ABORT_RANGE, 0, 0);
		sdo(0, IDX_MODE_REQUEST, 0, ACK_OK, 16'h000a, 1);
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h07 : 8'($urandom % 12);
			u_fieldbus_master.pdo_req(v);
			repeat (5) @(posedge core_clk);
			cur = (v inside {1, 3, 4, 6, 8, 9, 10}) ? v : cur;
			`chk("mode_display", cur, mode_display)
		end
		for (j = 0; j < 7; j++) begin
			sdo(1, IDX_MODE_REQUEST, {8'h00, modes[j]}, ACK_OK, 0, 0);
			for (c = 0; c < 8; c++) begin
				sdo(1, IDX_QUICK_STOP_OPTION, 16'(c), ACK_OK, 0, 0);
				u_fieldbus_master.set_stop(1, 16'($urandom));
				check_stop(modes[j], 1, 3'(c));
			end
			for (c = 1; c < 4; c++) begin
				sdo(1, IDX_HALT_STOP_OPTION, 16'(c), ACK_OK, 0, 0);
				u_fieldbus_master.set_stop(0, 16'($urandom) | 16'h0100);
				check_stop(modes[j], 0, 3'(c));
			end
		end
		u_fieldbus_master.set_stop(0, 16'($urandom) & 16'hfeff);
		repeat (2) @(posedge core_clk);
		`chk("stop_active", 1'b0, stop_active)
		@(posedge core_clk);
		#10 reset = 1'b1;
		@(posedge core_clk);
		#10 reset = 1'b0;
		`chk("mode_display", MODE_RESET, mode_display)
		sdo(0, IDX_HALT_STOP_OPTION, 0, ACK_OK, HALT_RESET, 1);
		final_report;
	end
endmodule : tb_top
